// ---- out_chan_regs.svh ----
/*
  register offsets, field positions, reset values and codes for the
  two-channel configurable output block.
  assumes a 32-bit apb bus with 12-bit byte addresses.
*/
`ifndef OUT_CHAN_REGS_SVH
`define OUT_CHAN_REGS_SVH

// ****************************************
// register map (channel stride in bytes, register word indices)
// ****************************************
`define OC_CH_STRIDE 12'h020
`define OC_CFG 3'h0
`define OC_THR 3'h1
`define OC_LTHR 3'h2
`define OC_HYST 3'h3
`define OC_DEB 3'h4
`define OC_START 3'h5
`define OC_END 3'h6
`define OC_STAT 3'h7

// ****************************************
// config register fields
// ****************************************
`define OC_SRC_LSB 0
`define OC_TYPE_LSB 2
`define OC_WIN_BIT 6
`define OC_NC_BIT 7
`define OC_DIR_LSB 8

// ****************************************
// status register fields
// ****************************************
`define OC_ST_ALARM 12
`define OC_ST_COND 13
`define OC_ST_ERR 14
`define OC_ST_CNT_LSB 16

// ****************************************
// reset values
// ****************************************
`define OC_CFG_RST 10'h010
`define OC_THR_RST 16'h0000
`define OC_LTHR_RST 16'h0000
`define OC_HYST_RST 16'h0000
`define OC_DEB_RST 8'h00
`define OC_START_RST 16'h0000
`define OC_END_RST 16'h7fff

// ****************************************
// output code levels (full scale = 20 mA / 10 V)
// ****************************************
`define OC_CODE_FULL 12'hfff
`define OC_CODE_LIVE0 12'h333
`define OC_CODE_ZERO 12'h000

`endif

// ---- out_chan_pkg.sv ----
/*
  types shared by the configurable output block.
  assumes out_chan_regs.svh holds the numeric constants.
*/
package out_chan_pkg;

  // measured variable feeding a channel
  typedef enum logic [1:0] {
    SRC_FLOW = 2'h0,
    SRC_VOLUME = 2'h1,
    SRC_TEMP = 2'h2,
    SRC_PART = 2'h3
  } src_type;

  // output kind of a channel
  typedef enum logic [3:0] {
    OT_CUR_4_20 = 4'h0,
    OT_CUR_0_20 = 4'h1,
    OT_VOLT_0_10 = 4'h2,
    OT_VOLT_2_10 = 4'h3,
    OT_ALARM = 4'h4,
    OT_PULSE = 4'h5,
    OT_FREQ = 4'h6,
    OT_IOLINK = 4'h7,
    OT_CTRL_IN = 4'h8
  } otype_type;

  // directions in which the debounce delay applies
  typedef enum logic [1:0] {
    DIR_HIGH = 2'h0,
    DIR_DOWN = 2'h1,
    DIR_BOTH = 2'h2
  } dir_type;

endpackage

// ---- out_chan.sv ----
/*
  two configurable output channels: alarm comparator with hysteresis,
  polarity and debounce, or a scaled analog output code, per channel.
  assumes an apb master on pclk and measured values from logic on the
  same clock, with a one-cycle strobe on each new measurement.
*/
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "out_chan_regs.svh"

// Function
// - two independent channels, each own configuration
// - source is flow, volume, temperature, partial volume
// - output type selects analog, alarm or others
// - limit mode: on above threshold, hysteresis off
// - window mode: active outside the window
// - hysteresis shrinks window at both edges
// - window normally-closed: active inside window
// - polarity resets normally-open, active above threshold
// - normally-closed: active below, off above threshold
// - threshold is limit or upper window edge
// - lower threshold ignored in limit mode
// - thresholds signed, comparisons signed
// - zero debounce immediate, else delayed samples
// - debounce applies high, down or both
// - new side held for count; return restarts
// - current maps start to 4/0 mA, end 20 mA
// - end value defaults range end, exceeds start
// - voltage maps start to 0/2 V, end 10 V
// - analog sources only flow or temperature
// - start point freely settable in range
module out_chan (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured variables
  input wire logic meas_strobe,
  input wire logic signed [15:0] flow_val,
  input wire logic signed [15:0] volume_val,
  input wire logic signed [15:0] temp_val,
  input wire logic signed [15:0] part_val,
  // channel outputs
  output logic [1:0] alarm_out,
  output logic [11:0] aout_code_0,
  output logic [11:0] aout_code_1
);

  // ****************************************
  // helper functions
  // ****************************************

  // sign-extend a 16-bit value for overflow-free sums
  function automatic logic signed [17:0] ext(input logic signed [15:0] v);
    ext = {{2{v[15]}}, v};
  endfunction

  // linear map of v from [start,stop] onto [lo,full], saturating
  function automatic logic [11:0] scale(input logic signed [15:0] v,
                                        input logic signed [15:0] start,
                                        input logic signed [15:0] stop,
                                        input logic [11:0] lo);
    logic [16:0] num;
    logic [16:0] span;
    logic [28:0] prod;
    logic [28:0] quo;
    num = 17'h00000;
    span = 17'h00001;
    prod = 29'h00000000;
    quo = 29'h00000000;
    if (ext(v) <= ext(start)) begin
      scale = lo;
    end else if (ext(v) >= ext(stop)) begin
      scale = `OC_CODE_FULL;
    end else begin
      num = 17'(ext(v) - ext(start));
      span = 17'(ext(stop) - ext(start));
      // widen both factors first so the product keeps all its bits
      prod = {12'h000, num} * {17'h00000, 12'(`OC_CODE_FULL - lo)};
      quo = prod / {12'h000, span};
      scale = 12'(lo + quo[11:0]);
    end
  endfunction

  // true for the four analog output kinds
  function automatic logic is_analog(input logic [3:0] t);
    is_analog = (t <= 4'(out_chan_pkg::OT_VOLT_2_10));
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [9:0] cfg_r [2];          // source, type, mode, polarity, direction
  logic [9:0] cfg_nxt [2];
  logic signed [15:0] thr_r [2];  // switching threshold / upper edge
  logic signed [15:0] thr_nxt [2];
  logic signed [15:0] lthr_r [2]; // lower window edge
  logic signed [15:0] lthr_nxt [2];
  logic [15:0] hyst_r [2];        // hysteresis amount
  logic [15:0] hyst_nxt [2];
  logic [7:0] deb_r [2];          // debounce_count in samples
  logic [7:0] deb_nxt [2];
  logic signed [15:0] start_r [2]; // start scaling point
  logic signed [15:0] start_nxt [2];
  logic signed [15:0] end_r [2];  // end scaling point
  logic signed [15:0] end_nxt [2];
  logic cond_r [2];               // committed above/outside state
  logic cond_nxt [2];
  logic [7:0] cnt_r [2];          // samples seen on the new side
  logic [7:0] cnt_nxt [2];
  logic err_r [2];                // analog configuration invalid
  logic err_nxt [2];
  logic [1:0] alarm_nxt;
  logic [11:0] code_nxt [2];
  logic [11:0] code_r [2];
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;

  // decoded bus fields
  logic sel_ch;
  logic [2:0] sel_reg;
  logic addr_ok;
  logic wr_en;

  assign sel_ch = paddr[5];
  assign sel_reg = paddr[4:2];
  assign addr_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
  // write strobe: access edge of a mapped write
  assign wr_en = psel && penable && pready && pwrite && addr_ok;

  // ****************************************
  // bus and channel next-state logic
  // ****************************************
  always_comb begin
    logic signed [15:0] v;
    logic signed [17:0] up_off;
    logic signed [17:0] lo_on;
    logic prop;
    logic delay;
    logic [3:0] t;
    logic [1:0] s;
    v = 16'h0000;
    up_off = 18'h00000;
    lo_on = 18'h00000;
    prop = 1'b0;
    delay = 1'b0;
    t = 4'h0;
    s = 2'h0;
    prdata_nxt = 32'h00000000;
    // one-cycle ready: set in setup, dropped after access
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !addr_ok;
    alarm_nxt = alarm_out;
    for (int c = 0; c < 2; c++) begin
      cfg_nxt[c] = cfg_r[c];
      thr_nxt[c] = thr_r[c];
      lthr_nxt[c] = lthr_r[c];
      hyst_nxt[c] = hyst_r[c];
      deb_nxt[c] = deb_r[c];
      start_nxt[c] = start_r[c];
      end_nxt[c] = end_r[c];
      cond_nxt[c] = cond_r[c];
      cnt_nxt[c] = cnt_r[c];
      err_nxt[c] = err_r[c];
      code_nxt[c] = code_r[c];
      // register write at the access edge
      if (wr_en && (sel_ch == 1'(c))) begin
        case (sel_reg)
          `OC_CFG: cfg_nxt[c] = pwdata[9:0];
          `OC_THR: thr_nxt[c] = pwdata[15:0];
          `OC_LTHR: lthr_nxt[c] = pwdata[15:0];
          `OC_HYST: hyst_nxt[c] = pwdata[15:0];
          `OC_DEB: deb_nxt[c] = pwdata[7:0];
          `OC_START: start_nxt[c] = pwdata[15:0];
          `OC_END: end_nxt[c] = pwdata[15:0];
          default: ;
        endcase
      end
      t = cfg_r[c][`OC_TYPE_LSB +: 4];
      s = cfg_r[c][`OC_SRC_LSB +: 2];
      case (s)
        2'(out_chan_pkg::SRC_FLOW): v = flow_val;
        2'(out_chan_pkg::SRC_VOLUME): v = volume_val;
        2'(out_chan_pkg::SRC_TEMP): v = temp_val;
        default: v = part_val;
      endcase
      // evaluate only on a new measurement
      if (meas_strobe) begin
        up_off = ext(thr_r[c]) - {2'b00, hyst_r[c]};
        lo_on = ext(lthr_r[c]) + {2'b00, hyst_r[c]};
        if (cfg_r[c][`OC_WIN_BIT]) begin
          // outside the window is the active side
          // re-enter only inside the shrunk window
          // threshold is the upper edge here
          if (cond_r[c]) begin
            prop = !((ext(v) < up_off) && (ext(v) > lo_on));
          end else begin
            prop = (v > thr_r[c]) || (v < lthr_r[c]);
          end
        end else begin
          // on above threshold, off below it minus hysteresis
          // lower threshold plays no part here
          if (cond_r[c]) begin
            prop = !(ext(v) < up_off);
          end else begin
            prop = (v > thr_r[c]);
          end
        end
        // does the delay apply in this direction
        case (cfg_r[c][`OC_DIR_LSB +: 2])
          2'(out_chan_pkg::DIR_HIGH): delay = prop;
          2'(out_chan_pkg::DIR_DOWN): delay = !prop;
          default: delay = 1'b1;
        endcase
        if (prop == cond_r[c]) begin
          // back on the old side restarts the count
          cnt_nxt[c] = 8'h00;
        // zero count or no delay switches at once
        end else if (!delay || (deb_r[c] == 8'h00) || (cnt_r[c] + 8'h01 >= deb_r[c])) begin
          cond_nxt[c] = prop;
          cnt_nxt[c] = 8'h00;
        end else begin
          cnt_nxt[c] = cnt_r[c] + 8'h01;
        end
        // analog only from flow or temperature
        // end point must exceed start point
        err_nxt[c] = is_analog(t) && ((s == 2'(out_chan_pkg::SRC_VOLUME))
                     || (s == 2'(out_chan_pkg::SRC_PART)) || (end_r[c] <= start_r[c]));
        if (!is_analog(t)) begin
          code_nxt[c] = `OC_CODE_ZERO;
        end else if (err_nxt[c]) begin
          // invalid setup parks the output at its start code
          code_nxt[c] = (t == 4'(out_chan_pkg::OT_CUR_4_20) ||
                         t == 4'(out_chan_pkg::OT_VOLT_2_10)) ? `OC_CODE_LIVE0 : `OC_CODE_ZERO;
        end else if (t == 4'(out_chan_pkg::OT_CUR_4_20) ||
                     t == 4'(out_chan_pkg::OT_VOLT_2_10)) begin
          // current start 4 mA, end 20 mA
          // voltage start 2 V, end 10 V
          code_nxt[c] = scale(v, start_r[c], end_r[c], `OC_CODE_LIVE0);
        end else begin
          // 0-20 mA and 0-10 V start at zero
          code_nxt[c] = scale(v, start_r[c], end_r[c], `OC_CODE_ZERO);
        end
        // only the alarm type drives the switch output
        // normally-closed window inverts the active side
        alarm_nxt[c] = (t == 4'(out_chan_pkg::OT_ALARM)) &&
                       (cond_nxt[c] ^ cfg_r[c][`OC_NC_BIT]);
      end
    end
    // read data captured in the setup cycle
    if (psel && !penable && !pwrite && addr_ok) begin
      for (int c = 0; c < 2; c++) begin
        if (sel_ch == 1'(c)) begin
          case (sel_reg)
            `OC_CFG: prdata_nxt = {22'h000000, cfg_r[c]};
            `OC_THR: prdata_nxt = {{16{thr_r[c][15]}}, thr_r[c]};
            `OC_LTHR: prdata_nxt = {{16{lthr_r[c][15]}}, lthr_r[c]};
            `OC_HYST: prdata_nxt = {16'h0000, hyst_r[c]};
            `OC_DEB: prdata_nxt = {24'h000000, deb_r[c]};
            `OC_START: prdata_nxt = {{16{start_r[c][15]}}, start_r[c]};
            `OC_END: prdata_nxt = {{16{end_r[c][15]}}, end_r[c]};
            default: begin
              prdata_nxt[11:0] = code_r[c];
              prdata_nxt[`OC_ST_ALARM] = alarm_out[c];
              prdata_nxt[`OC_ST_COND] = cond_r[c];
              prdata_nxt[`OC_ST_ERR] = err_r[c];
              prdata_nxt[`OC_ST_CNT_LSB +: 8] = cnt_r[c];
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      alarm_out <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        cfg_r[c] <= `OC_CFG_RST;
        thr_r[c] <= `OC_THR_RST;
        lthr_r[c] <= `OC_LTHR_RST;
        hyst_r[c] <= `OC_HYST_RST;
        deb_r[c] <= `OC_DEB_RST;
        start_r[c] <= `OC_START_RST;
        // end point defaults to range end
        end_r[c] <= `OC_END_RST;
        cond_r[c] <= 1'b0;
        cnt_r[c] <= 8'h00;
        err_r[c] <= 1'b0;
        code_r[c] <= `OC_CODE_ZERO;
      end
    end else begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      alarm_out <= alarm_nxt;
      for (int c = 0; c < 2; c++) begin
        cfg_r[c] <= cfg_nxt[c];
        thr_r[c] <= thr_nxt[c];
        lthr_r[c] <= lthr_nxt[c];
        hyst_r[c] <= hyst_nxt[c];
        deb_r[c] <= deb_nxt[c];
        start_r[c] <= start_nxt[c];
        end_r[c] <= end_nxt[c];
        cond_r[c] <= cond_nxt[c];
        cnt_r[c] <= cnt_nxt[c];
        err_r[c] <= err_nxt[c];
        code_r[c] <= code_nxt[c];
      end
    end
  end

  // analog codes leave straight from their flops
  assign aout_code_0 = code_r[0];
  assign aout_code_1 = code_r[1];

endmodule

// ---- out_chan_sva.sv ----
/*
  port checker for the two-channel output block.
  assumes it is bound to out_chan and sees only its ports.
*/
`timescale 1ns/1ps
// ****************************************
// checker
// ****************************************
module out_chan_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // measurement and outputs
  input wire logic meas_strobe,
  input wire logic [1:0] alarm_out,
  input wire logic [11:0] aout_code_0,
  input wire logic [11:0] aout_code_1
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup phase of a transfer
  wire setup = psel && !penable;
  // address outside the map or not word aligned
  wire bad_adr = (paddr[11:6] != 6'h00) || (paddr[1:0] != 2'h0);
  chk_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_cause: assert property (pready |-> $past(setup))
    else $error("pready without setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (setup && bad_adr |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (setup && !bad_adr |=> !pslverr)
    else $error("mapped access refused");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  chk_alarm_hold: assert property (!meas_strobe |=> $stable(alarm_out))
    else $error("alarm moved without strobe");
  chk_code_hold: assert property (!meas_strobe |=> $stable({aout_code_0, aout_code_1}))
    else $error("code moved without strobe");
  // main scenarios
  cov_unmapped: cover property (setup && bad_adr);
  cov_alarm: cover property (meas_strobe ##1 $changed(alarm_out));
  cov_full: cover property (meas_strobe ##1 aout_code_1 == 12'hfff);
endmodule
bind out_chan out_chan_sva out_chan_sva_inst (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .meas_strobe, .alarm_out, .aout_code_0, .aout_code_1);

// ---- meas_model.sv ----
/*
  measurement source in front of the output block.
  assumes send is called from the bench between pclk edges.
*/
`timescale 1ns/1ps
module meas_model (
  // clock
  input wire logic pclk,
  // measured variables
  output logic meas_strobe,
  output logic signed [15:0] flow_val,
  output logic signed [15:0] volume_val,
  output logic signed [15:0] temp_val,
  output logic signed [15:0] part_val
);
  // idle at time zero
  initial begin
    meas_strobe = 1'b0;
    flow_val = 16'sh0000;
    volume_val = 16'sh0000;
    temp_val = 16'sh0000;
    part_val = 16'sh0000;
  end
  // one strobe cycle, then scramble values so stale data is not reused
  task automatic send(input logic signed [15:0] f, input logic signed [15:0] t);
    @(posedge pclk);
    meas_strobe <= 1'b1;
    flow_val <= f;
    volume_val <= 16'sh0007;
    temp_val <= t;
    part_val <= f;
    @(posedge pclk);
    meas_strobe <= 1'b0;
    flow_val <= ~f;
    volume_val <= ~16'sh0007;
    temp_val <= ~t;
    part_val <= ~f;
  endtask
endmodule

// ---- out_chan_tb_top.sv ----
/*
  self-checking bench for the output block over apb.
  assumes out_chan, meas_model and the register header.
*/
`timescale 1ns/1ps
`include "out_chan_regs.svh"
module out_chan_tb_top;
  // apb and outputs
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_strobe, err;
  logic [11:0] paddr, aout_code_0, aout_code_1;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] flow_val, volume_val, temp_val, part_val;
  logic [1:0] alarm_out;
  int num_errors, n_tests;
  localparam logic signed [15:0] pos5 = 16'sh0005, neg1 = 16'shffff;
  out_chan out_chan_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .meas_strobe, .flow_val, .volume_val, .temp_val,
    .part_val, .alarm_out, .aout_code_0, .aout_code_1);
  meas_model meas_model_inst (.pclk, .meas_strobe, .flow_val, .volume_val, .temp_val,
    .part_val);
  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic c, input logic [2:0] r, input logic [31:0] d);
    apb(1'b1, {6'h00, c, r, 2'h0}, d);
  endtask
  task automatic rdc(input string nm, input logic c, input logic [2:0] r, input logic [31:0] e);
    apb(1'b0, {6'h00, c, r, 2'h0}, 32'h0);
    check(nm, rd, e);
  endtask
  // strobes a list of values on flow (ch 0) or temp (ch 1), checks alarms
  task automatic run(input logic c, input logic signed [15:0] o,
      input logic signed [15:0] v[$], input logic [1:0] ev[$]);
    foreach (v[i]) begin
      meas_model_inst.send(c ? o : v[i], c ? v[i] : o);
      @(negedge pclk);
      check("alarm", {30'h0, alarm_out}, {30'h0, ev[i]});
    end
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, num_errors, n_tests} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped access, signed read-back
    rdc("cfg0", 1'b0, `OC_CFG, 32'h0000_0010);
    rdc("end1", 1'b1, `OC_END, 32'h0000_7fff);
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    wr(1'b0, `OC_THR, 32'h0000_fff6);
    rdc("thr0", 1'b0, `OC_THR, 32'hffff_fff6);
    // ch 1 window on temperature, ch 0 limit with a misleading lower bound
    wr(1'b1, `OC_CFG, 32'h52);
    wr(1'b1, `OC_THR, 32'h64);
    wr(1'b1, `OC_LTHR, 32'hff9c);
    wr(1'b1, `OC_HYST, 32'ha);
    wr(1'b0, `OC_LTHR, 32'h7fff);
    wr(1'b0, `OC_HYST, 32'h5);
    run(1'b0, 16'sh0, {16'shfff4, 16'shfff7, 16'shfff2, 16'shfff0}, {2'h0, 2'h1, 2'h1, 2'h0});
    wr(1'b0, `OC_CFG, 32'h90);
    run(1'b0, 16'sh0, {16'shfff0, 16'shfff7}, {2'h1, 2'h0});
    wr(1'b0, `OC_CFG, 32'h10);
    run(1'b1, 16'shfff7, {16'sh0, 16'sh65, 16'sh5f, 16'sh50, 16'shff9b, 16'shffa1,
      16'shffb0}, {2'h1, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h1});
    wr(1'b1, `OC_CFG, 32'hd2);
    run(1'b1, 16'shfff7, {16'sh0}, {2'h3});
    // debounce of three samples in each direction setting
    wr(1'b0, `OC_THR, 32'h0);
    wr(1'b0, `OC_HYST, 32'h0);
    wr(1'b0, `OC_DEB, 32'h3);
    run(1'b0, 16'sh0, {neg1, pos5, pos5, neg1, pos5, pos5, pos5},
      {2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3});
    wr(1'b0, `OC_CFG, 32'h110);
    run(1'b0, 16'sh0, {neg1, neg1, neg1}, {2'h3, 2'h3, 2'h2});
    wr(1'b0, `OC_CFG, 32'h210);
    run(1'b0, 16'sh0, {pos5, pos5, pos5}, {2'h2, 2'h2, 2'h3});
    // analog scaling on ch 1, start 0, end 100, all four ranges
    wr(1'b1, `OC_END, 32'h64);
    for (int ty = 0; ty < 4; ty++) begin
      wr(1'b1, `OC_CFG, 32'(ty) << 2);
      meas_model_inst.send(16'sh32, 16'sh0);
      @(negedge pclk);
      check("code1", {20'h0, aout_code_1}, (ty == 1 || ty == 2) ? 32'h7ff : 32'h999);
    end
    wr(1'b1, `OC_CFG, 32'h0);
    meas_model_inst.send(16'shfffb, 16'sh0);
    @(negedge pclk);
    check("code1", {20'h0, aout_code_1}, 32'h333);
    meas_model_inst.send(16'shc8, 16'sh0);
    @(negedge pclk);
    check("code1", {20'h0, aout_code_1}, 32'hfff);
    check("alarm1", {31'h0, alarm_out[1]}, 32'h0);
    check("code0", {20'h0, aout_code_0}, 32'h0);
    // volume is no analog source: parked at start code, error flag
    wr(1'b1, `OC_CFG, 32'h1);
    meas_model_inst.send(16'sh32, 16'sh0);
    @(negedge pclk);
    check("code1", {20'h0, aout_code_1}, 32'h333);
    rdc("err1", 1'b1, `OC_STAT, 32'h0000_4333);
    give_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end
endmodule
